// File: logic/pei_pkg.sv
// package: register map, field layout and reset values of the power event block
package pei_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int NUM_EVT = 3;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CONST_LATENCY_TRIGGER = 12'h078;
  localparam logic [ADDR_W-1:0] OFF_LOW_POWER_MODE_TRIGGER = 12'h07c;
  localparam logic [ADDR_W-1:0] OFF_SUPPLY_DROP_WARNING_EVENT = 12'h108;
  localparam logic [ADDR_W-1:0] OFF_SLEEP_ENTRY_EVENT = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_SLEEP_EXIT_EVENT = 12'h118;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET = 12'h304;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [ADDR_W-1:0] OFF_EVENT_PENDING = 12'h30c;
  localparam logic [ADDR_W-1:0] OFF_MODE_STATUS = 12'h5fc;

  // ==========================================================================
  // field positions
  localparam int POS_TRIGGER     = 0;
  localparam int POS_EVENT_FLAG  = 0;
  localparam int POS_SUPPLY_DROP = 0;
  localparam int POS_SLEEP_ENTRY = 1;
  localparam int POS_SLEEP_EXIT  = 2;
  localparam int POS_MODE        = 0;

  // ==========================================================================
  // reset values
  localparam logic [NUM_EVT-1:0] RST_IRQ_ENABLE = 3'h0;
  localparam logic [NUM_EVT-1:0] RST_EVENT      = 3'h0;
  localparam logic [DATA_W-1:0]  RST_RDATA      = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  UNMAPPED_RDATA = 32'h0000_0000;

  // ==========================================================================
  // latency modes
  typedef enum logic {
    PEI_MODE_LOW_POWER,
    PEI_MODE_CONST_LATENCY
  } pei_mode_t;

  localparam pei_mode_t RST_MODE = PEI_MODE_LOW_POWER;

  // ==========================================================================
  // helpers
  function automatic logic pei_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    return addr == off;
  endfunction

  function automatic logic [DATA_W-1:0] pei_word(input logic [NUM_EVT-1:0] v);
    return {{(DATA_W-NUM_EVT){1'b0}}, v};
  endfunction

endpackage

// File: logic/pei_event_flag.sv
// one sticky event flag: hardware set, software rewrite and write-one clear
`timescale 1ns/1ps
module pei_event_flag
  import pei_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic hw_set,
  input  wire logic sw_wr,
  input  wire logic sw_bit,
  input  wire logic sw_w1c,
  output logic      flag
);

  logic flag_reg;
  logic flag_next;

  // ==========================================================================
  // next value: a hardware event beats any software write in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (hw_set) begin
      flag_next = 1'b1;
    end else if (sw_wr) begin
      flag_next = sw_bit;
    end else if (sw_w1c) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
    end else if (ce) begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_set_beats_clear: assert property (ce && hw_set |=> flag_reg)
    else $error("event lost against a simultaneous clear");

endmodule

// File: logic/pei_regs.sv
// top: power event registers, latency mode selection and interrupt output
`timescale 1ns/1ps
module pei_regs
  import pei_pkg::*;
(
  input  wire logic                      SYS_CLK,
  input  wire logic                      NRST,
  input  wire logic                      CE,
  input  wire logic [pei_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [pei_pkg::DATA_W-1:0] WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [pei_pkg::DATA_W-1:0] RDATA,
  input  wire logic                      SUPPLY_DROP_WARNING,
  input  wire logic                      CPU_SLEEP,
  output logic                           CONST_LATENCY,
  output logic                           IRQ
);

  // ==========================================================================
  // declarations
  pei_mode_t            mode_reg;
  logic [NUM_EVT-1:0]   irq_en_reg;
  logic [NUM_EVT-1:0]   irq_en_next;
  logic [NUM_EVT-1:0]   evt_flag;
  logic [NUM_EVT-1:0]   evt_set;
  logic [NUM_EVT-1:0]   evt_wr;
  logic [NUM_EVT-1:0]   evt_w1c;
  logic                 sleep_prev_reg;
  logic                 sleep_entry;
  logic                 sleep_exit_a;
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;
  logic                 irq_reg;
  logic                 wr_go;
  logic                 rd_go;
  logic                 wr_low_power;
  logic                 wr_const_lat;
  logic                 wr_en_set;
  logic                 wr_en_clr;
  logic                 wr_pending;

  assign wr_go = WR && CE;
  assign rd_go = RD && CE;

  // ==========================================================================
  // write decode
  assign wr_low_power = wr_go && pei_hit(ADDR, OFF_LOW_POWER_MODE_TRIGGER);
  assign wr_const_lat = wr_go && pei_hit(ADDR, OFF_CONST_LATENCY_TRIGGER);
  assign wr_en_set    = wr_go && pei_hit(ADDR, OFF_IRQ_ENABLE_SET);
  assign wr_en_clr    = wr_go && pei_hit(ADDR, OFF_IRQ_ENABLE_CLEAR);
  assign wr_pending   = wr_go && pei_hit(ADDR, OFF_EVENT_PENDING);

  // ==========================================================================
  // latency mode: the two triggers are write-only, only bit 0 matters
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_reg <= RST_MODE;
    end else if (CE) begin
      if (wr_low_power && WDATA[POS_TRIGGER]) begin
        mode_reg <= PEI_MODE_LOW_POWER;
      end else if (wr_const_lat && WDATA[POS_TRIGGER]) begin
        mode_reg <= PEI_MODE_CONST_LATENCY;
      end
    end
  end

  assign CONST_LATENCY = (mode_reg == PEI_MODE_CONST_LATENCY);

  // ==========================================================================
  // sleep edge detection on the synchronous sleep level
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sleep_prev_reg <= 1'b0;
    end else if (CE) begin
      sleep_prev_reg <= CPU_SLEEP;
    end
  end

  assign sleep_entry  = CPU_SLEEP && !sleep_prev_reg;
  assign sleep_exit_a = !CPU_SLEEP && sleep_prev_reg;

  // ==========================================================================
  // event flags
  always_comb begin
    evt_set                  = RST_EVENT;
    evt_set[POS_SUPPLY_DROP] = SUPPLY_DROP_WARNING;
    evt_set[POS_SLEEP_ENTRY] = sleep_entry;
    evt_set[POS_SLEEP_EXIT]  = sleep_exit_a;
  end

  always_comb begin
    evt_wr                  = RST_EVENT;
    evt_wr[POS_SUPPLY_DROP] = wr_go && pei_hit(ADDR, OFF_SUPPLY_DROP_WARNING_EVENT);
    evt_wr[POS_SLEEP_ENTRY] = wr_go && pei_hit(ADDR, OFF_SLEEP_ENTRY_EVENT);
    evt_wr[POS_SLEEP_EXIT]  = wr_go && pei_hit(ADDR, OFF_SLEEP_EXIT_EVENT);
  end

  // pending register mirrors the flags in enable layout, write one clears
  assign evt_w1c = wr_pending ? WDATA[NUM_EVT-1:0] : RST_EVENT;

  for (genvar i = 0; i < NUM_EVT; i++) begin : g_evt
    pei_event_flag u_flag (
      .clk    (SYS_CLK),
      .nrst   (NRST),
      .ce     (CE),
      .hw_set (evt_set[i]),
      .sw_wr  (evt_wr[i]),
      .sw_bit (WDATA[POS_EVENT_FLAG]),
      .sw_w1c (evt_w1c[i]),
      .flag   (evt_flag[i])
    );
  end

  // ==========================================================================
  // interrupt enables: set and clear registers share one state
  always_comb begin
    irq_en_next = irq_en_reg;
    if (wr_en_set) begin
      irq_en_next = irq_en_reg | WDATA[NUM_EVT-1:0];
    end else if (wr_en_clr) begin
      irq_en_next = irq_en_reg & ~WDATA[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_en_reg <= RST_IRQ_ENABLE;
    end else if (CE) begin
      irq_en_reg <= irq_en_next;
    end
  end

  // ==========================================================================
  // interrupt output, registered so it is glitch free at the core
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_reg <= 1'b0;
    end else if (CE) begin
      irq_reg <= |(evt_flag & irq_en_reg);
    end
  end

  assign IRQ = irq_reg;

  // ==========================================================================
  // read path: data in the cycle after the strobe, zero after any other cycle with CE high, held while CE is low
  always_comb begin
    rdata_next = UNMAPPED_RDATA;
    case (ADDR)
      OFF_SUPPLY_DROP_WARNING_EVENT: begin
        rdata_next = pei_word({2'h0, evt_flag[POS_SUPPLY_DROP]});
      end
      OFF_SLEEP_ENTRY_EVENT: begin
        rdata_next = pei_word({2'h0, evt_flag[POS_SLEEP_ENTRY]});
      end
      OFF_SLEEP_EXIT_EVENT: begin
        rdata_next = pei_word({2'h0, evt_flag[POS_SLEEP_EXIT]});
      end
      OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR: begin
        rdata_next = pei_word(irq_en_reg);
      end
      OFF_EVENT_PENDING: begin
        rdata_next = pei_word(evt_flag);
      end
      OFF_MODE_STATUS: begin
        rdata_next = pei_word({2'h0, CONST_LATENCY});
      end
      default: begin
        // triggers are write-only and read as zero, like unmapped space
        rdata_next = UNMAPPED_RDATA;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_reg <= RST_RDATA;
    end else if (CE) begin
      rdata_reg <= rd_go ? rdata_next : RST_RDATA;
    end
  end

  assign RDATA = rdata_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence s_low_power_write;
    wr_low_power && WDATA[POS_TRIGGER];
  endsequence

  sequence s_enabled_event(int idx);
    CE && irq_en_reg[idx] && evt_set[idx] && !wr_en_clr;
  endsequence

  a_low_power_trigger: assert property (
    s_low_power_write |=> !CONST_LATENCY)
    else $error("low-power trigger did not select low-power mode");

  a_trigger_zero_ignored: assert property (
    wr_low_power && !WDATA[POS_TRIGGER] |=> $stable(CONST_LATENCY))
    else $error("zero write to low-power trigger changed the mode");

  a_const_trigger: assert property (
    wr_const_lat && WDATA[POS_TRIGGER] |=> CONST_LATENCY)
    else $error("constant-latency trigger did not select that mode");

  a_entry_flag_set: assert property (
    CE && CPU_SLEEP && !sleep_prev_reg |=> evt_flag[POS_SLEEP_ENTRY])
    else $error("sleep entry did not set its event flag");

  a_exit_flag_set: assert property (
    CE && !CPU_SLEEP && sleep_prev_reg |=> evt_flag[POS_SLEEP_EXIT])
    else $error("sleep exit did not set its event flag");

  a_enable_set_ones: assert property (
    wr_en_set |=> (irq_en_reg & $past(WDATA[NUM_EVT-1:0])) == $past(WDATA[NUM_EVT-1:0]))
    else $error("set register failed to enable an interrupt");

  a_enable_set_zeros: assert property (
    wr_en_set |=> (irq_en_reg & ~$past(WDATA[NUM_EVT-1:0]))
                  == ($past(irq_en_reg) & ~$past(WDATA[NUM_EVT-1:0])))
    else $error("zero bits in set register changed an enable");

  a_enable_clear: assert property (
    wr_en_clr |=> (irq_en_reg & $past(WDATA[NUM_EVT-1:0])) == 3'h0)
    else $error("clear register failed to disable an interrupt");

  a_enable_readback: assert property (
    rd_go && (pei_hit(ADDR, OFF_IRQ_ENABLE_SET) || pei_hit(ADDR, OFF_IRQ_ENABLE_CLEAR))
    |=> RDATA == pei_word($past(irq_en_reg)))
    else $error("enable readback does not match enable state");

  a_irq_follows: assert property (
    s_enabled_event(POS_SUPPLY_DROP) ##1 CE |=> IRQ)
    else $error("enabled event did not raise the interrupt");

  a_irq_quiet: assert property (
    CE && (evt_flag & irq_en_reg) == 3'h0 |=> !IRQ)
    else $error("interrupt high with no enabled flag set");

  a_read_one_cycle: assert property (
    CE && !RD |=> RDATA == RST_RDATA)
    else $error("read data held beyond its cycle");

  // ==========================================================================
  // per-event checks: software access, readback and interrupt paths
  // a hardware set in the same cycle is excluded, it wins by design
  sequence s_sw_flag_write(int idx);
    evt_wr[idx] && !evt_set[idx];
  endsequence

  sequence s_pending_clear(int idx);
    wr_pending && WDATA[idx] && !evt_set[idx];
  endsequence

  sequence s_reg_read(logic [ADDR_W-1:0] off);
    rd_go && pei_hit(ADDR, off);
  endsequence

  a_supply_flag_set: assert property (
    CE && SUPPLY_DROP_WARNING |=> evt_flag[POS_SUPPLY_DROP])
    else $error("supply warning did not set its event flag");

  a_entry_irq: assert property (
    s_enabled_event(POS_SLEEP_ENTRY) ##1 CE |=> IRQ)
    else $error("enabled sleep entry did not raise the interrupt");

  a_exit_irq: assert property (
    s_enabled_event(POS_SLEEP_EXIT) ##1 CE |=> IRQ)
    else $error("enabled sleep exit did not raise the interrupt");

  a_set_keeps_on: assert property (
    wr_en_set |=> (irq_en_reg & $past(irq_en_reg)) == $past(irq_en_reg))
    else $error("set register disabled an interrupt");

  a_clear_keeps_rest: assert property (
    wr_en_clr |=> (irq_en_reg & ~$past(WDATA[NUM_EVT-1:0]))
                  == ($past(irq_en_reg) & ~$past(WDATA[NUM_EVT-1:0])))
    else $error("zero bits in clear register changed an enable");

  a_clear_sleep_bits: assert property (
    wr_en_clr |=> (irq_en_reg[POS_SLEEP_EXIT:POS_SLEEP_ENTRY]
                   & $past(WDATA[POS_SLEEP_EXIT:POS_SLEEP_ENTRY])) == 2'h0)
    else $error("clear register failed to disable a sleep interrupt");

  a_entry_readback: assert property (
    s_reg_read(OFF_SLEEP_ENTRY_EVENT)
    |=> RDATA == pei_word({2'h0, $past(evt_flag[POS_SLEEP_ENTRY])}))
    else $error("sleep entry flag readback wrong");

  a_exit_readback: assert property (
    s_reg_read(OFF_SLEEP_EXIT_EVENT)
    |=> RDATA == pei_word({2'h0, $past(evt_flag[POS_SLEEP_EXIT])}))
    else $error("sleep exit flag readback wrong");

  a_trigger_read_zero: assert property (
    s_reg_read(OFF_LOW_POWER_MODE_TRIGGER) |=> RDATA == UNMAPPED_RDATA)
    else $error("write-only trigger did not read as zero");

  a_entry_sw_write: assert property (
    s_sw_flag_write(POS_SLEEP_ENTRY)
    |=> evt_flag[POS_SLEEP_ENTRY] == $past(WDATA[POS_EVENT_FLAG]))
    else $error("software write to sleep entry flag lost");

  a_exit_sw_write: assert property (
    s_sw_flag_write(POS_SLEEP_EXIT)
    |=> evt_flag[POS_SLEEP_EXIT] == $past(WDATA[POS_EVENT_FLAG]))
    else $error("software write to sleep exit flag lost");

  a_pending_clear: assert property (
    s_pending_clear(POS_SUPPLY_DROP) |=> !evt_flag[POS_SUPPLY_DROP])
    else $error("pending write-one did not clear the flag");

  a_mode_holds: assert property (
    !wr_low_power && !wr_const_lat |=> $stable(CONST_LATENCY))
    else $error("latency mode changed without a trigger");

  // ==========================================================================
  // clock enable low must freeze every flop, strobes included
  a_freeze_state: assert property (
    !CE |=> $stable(irq_en_reg) && $stable(evt_flag) && $stable(mode_reg))
    else $error("state moved while the clock enable was low");

  a_freeze_outputs: assert property (
    !CE |=> $stable(IRQ) && $stable(RDATA))
    else $error("outputs moved while the clock enable was low");

endmodule

// File: tb/pei_cpu_model.sv
// partner model: processor sleep state and supply warning source
`timescale 1ns/1ps
module pei_cpu_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sleep_req,
  input  wire logic warn_req,
  output logic      cpu_sleep,
  output logic      supply_drop_warning
);
  // ==========================================================================
  // sleep level and warning pulse
  logic warn_q;

  // a held request gives one pulse, so one warning stays one event
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_sleep           <= 1'b0;
      warn_q              <= 1'b0;
      supply_drop_warning <= 1'b0;
    end else begin
      cpu_sleep           <= sleep_req;
      warn_q              <= warn_req;
      supply_drop_warning <= warn_req & ~warn_q;
    end
  end
endmodule

// File: tb/pei_regs_tb.sv
// testbench: register access, events, interrupt and mode selection
`timescale 1ns/1ps
module pei_regs_tb;
  import pei_pkg::*;
  logic              sys_clk;
  logic              nrst;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              sleep_req;
  logic              warn_req;
  logic              cpu_sleep;
  logic              supply_drop;
  logic              const_latency;
  logic              irq;
  int                err_count;
  int                comparisons;

  pei_regs dut (.SYS_CLK(sys_clk), .NRST(nrst), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SUPPLY_DROP_WARNING(supply_drop),
    .CPU_SLEEP(cpu_sleep), .CONST_LATENCY(const_latency), .IRQ(irq));

  pei_cpu_model cpu (.clk(sys_clk), .nrst(nrst), .sleep_req(sleep_req),
    .warn_req(warn_req), .cpu_sleep(cpu_sleep), .supply_drop_warning(supply_drop));

  // ==========================================================================
  // clock and access tasks
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    #1;
  endtask

  // read data stands in the cycle after the strobe and is cleared by the next cycle with the clock enable high
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("irq", {31'h0, irq}, {31'h0, exp});
    // a used-up bound has been counted above and ends the run here
    if (irq !== exp) begin
      finish_test();
    end
  endtask

  task automatic warn_pulse;
    @(posedge sys_clk);
    warn_req <= 1'b1;
    @(posedge sys_clk);
    warn_req <= 1'b0;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 4000);
    err_count++;
    $display("ERROR run time expected end seen hang");
    finish_test();
  end

  // ==========================================================================
  // main sequence
  localparam logic [ADDR_W-1:0] RST_OFFS [6] = '{OFF_LOW_POWER_MODE_TRIGGER,
    OFF_SUPPLY_DROP_WARNING_EVENT, OFF_SLEEP_ENTRY_EVENT, OFF_SLEEP_EXIT_EVENT,
    OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR};

  initial begin
    nrst        = 1'b0;
    ce          = 1'b1;
    addr        = 12'h000;
    wdata       = 32'h0000_0000;
    wr          = 1'b0;
    rd          = 1'b0;
    sleep_req   = 1'b0;
    warn_req    = 1'b0;
    err_count   = 0;
    comparisons = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check("mode after reset", {31'h0, const_latency}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rd_chk("reset value", RST_OFFS[i], 32'h0);
    end
    $display("test reset done");

    for (int i = 0; i < NUM_EVT; i++) begin
      wr_reg(OFF_IRQ_ENABLE_SET, 32'h1 << i);
      wr_reg(OFF_IRQ_ENABLE_SET, 32'h0);
      rd_chk("enable set", OFF_IRQ_ENABLE_SET, 32'h1 << i);
      rd_chk("enable clear view", OFF_IRQ_ENABLE_CLEAR, 32'h1 << i);
      wr_reg(OFF_IRQ_ENABLE_SET, 32'h7);
      wr_reg(OFF_IRQ_ENABLE_CLEAR, 32'h1 << i);
      rd_chk("enable one cleared", OFF_IRQ_ENABLE_SET, 32'h7 ^ (32'h1 << i));
      wr_reg(OFF_IRQ_ENABLE_CLEAR, 32'h7);
    end
    $display("test enables done");

    wr_reg(OFF_IRQ_ENABLE_SET, 32'h7);
    warn_pulse();
    wait_irq(1'b1);
    rd_chk("supply flag", OFF_SUPPLY_DROP_WARNING_EVENT, 32'h1);
    wr_reg(OFF_SUPPLY_DROP_WARNING_EVENT, 32'h0);
    wait_irq(1'b0);
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    wait_irq(1'b1);
    rd_chk("entry flag", OFF_SLEEP_ENTRY_EVENT, 32'h1);
    rd_chk("exit flag idle", OFF_SLEEP_EXIT_EVENT, 32'h0);
    wr_reg(OFF_SLEEP_ENTRY_EVENT, 32'h0);
    wait_irq(1'b0);
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    wait_irq(1'b1);
    rd_chk("exit flag", OFF_SLEEP_EXIT_EVENT, 32'h1);
    wr_reg(OFF_SLEEP_EXIT_EVENT, 32'h0);
    wait_irq(1'b0);
    $display("test events done");

    // masked event must stay silent until enabled
    wr_reg(OFF_IRQ_ENABLE_CLEAR, 32'h7);
    warn_pulse();
    repeat (6) @(posedge sys_clk);
    #1;
    check("masked irq", {31'h0, irq}, 32'h0);
    wr_reg(OFF_IRQ_ENABLE_SET, 32'h1);
    wait_irq(1'b1);
    wr_reg(OFF_IRQ_ENABLE_CLEAR, 32'h1);
    wait_irq(1'b0);
    wr_reg(OFF_SUPPLY_DROP_WARNING_EVENT, 32'h0);
    wr_reg(OFF_SLEEP_EXIT_EVENT, 32'h1);
    rd_chk("exit flag by software", OFF_SLEEP_EXIT_EVENT, 32'h1);
    wr_reg(OFF_SLEEP_EXIT_EVENT, 32'h0);
    $display("test mask done");

    wr_reg(OFF_CONST_LATENCY_TRIGGER, 32'h1);
    check("const mode", {31'h0, const_latency}, 32'h1);
    rd_chk("mode status const", OFF_MODE_STATUS, 32'h1);
    wr_reg(OFF_LOW_POWER_MODE_TRIGGER, 32'h0);
    check("zero trigger", {31'h0, const_latency}, 32'h1);
    wr_reg(OFF_LOW_POWER_MODE_TRIGGER, 32'h1);
    check("low power mode", {31'h0, const_latency}, 32'h0);
    rd_chk("mode status low", OFF_MODE_STATUS, 32'h0);
    rd_chk("trigger reads zero", OFF_LOW_POWER_MODE_TRIGGER, 32'h0);
    rd_chk("unmapped", 12'h200, 32'h0);
    $display("test modes done");

    // pending view collects the flags, a written one clears its flag
    warn_pulse();
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk("pending view", OFF_EVENT_PENDING, 32'h3);
    wr_reg(OFF_EVENT_PENDING, 32'h1);
    rd_chk("pending one cleared", OFF_EVENT_PENDING, 32'h2);
    $display("test pending done");

    // reset in mid-run returns every register to its reset value
    wr_reg(OFF_IRQ_ENABLE_SET, 32'h7);
    wr_reg(OFF_CONST_LATENCY_TRIGGER, 32'h1);
    check("irq before reset", {31'h0, irq}, 32'h1);
    @(posedge sys_clk);
    nrst      <= 1'b0;
    sleep_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check("irq after reset", {31'h0, irq}, 32'h0);
    check("mode after second reset", {31'h0, const_latency}, 32'h0);
    rd_chk("enable after reset", OFF_IRQ_ENABLE_SET, 32'h0);
    rd_chk("pending after reset", OFF_EVENT_PENDING, 32'h0);
    $display("test second reset done");

    // strobes while the clock enable is low are ignored
    @(posedge sys_clk);
    ce <= 1'b0;
    wr_reg(OFF_IRQ_ENABLE_SET, 32'h7);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd_chk("frozen enable", OFF_IRQ_ENABLE_SET, 32'h0);
    $display("test clock enable done");
    finish_test();
  end
endmodule
